// [logic/timer_channel_pkg.sv]
// Operation
// - counter read buffer returns the live counter without disturbing counting
// - each capture/compare register works as capture or compare per option bits
// - compare writes to capture_compare_0 load a hidden buffer matched against counter
// - counter equal to buffer 0 pulses match_irq_0
// - buffer 0 is not software visible and resets to 0000h
// - compare writes to capture_compare_1 load its own hidden buffer
// - counter equal to buffer 1 pulses match_irq_1
// - buffer 1 is not software visible and resets to 0000h
// - input edge detect selects none, rising, falling or both edges
// - output pins toggle on compare matches, enabled and inverted by timer_output_control
// - count clock is one of eight prescaler taps or external event edges
// - timer_input_0 is capture trigger and event input
// - per-channel implemented bit masks; missing bits read as zero
// - both capture/compare registers and read buffer exist on every channel
// - two 8-bit control registers hold enable, clock select and mode
// - three 8-bit I/O registers hold output, capture edge, event/trigger edges
// - option register selects capture/compare use and holds overflow flag
// - disabled counter sits at ffffh while read buffer returns 0000h
// - counter overflow after ffffh pulses overflow_irq
// - clearing enable resets counter, overflow flag and outputs; setting starts
// - clock select divides by 1..128; odd channels top codes give 256, 512
package timer_channel_pkg;
	// ---------------------------------------------------------------
	// register byte offsets
	// ---------------------------------------------------------------
	localparam logic [5:0] OFS_CONTROL_0     = 6'h00;
	localparam logic [5:0] OFS_CONTROL_1     = 6'h04;
	localparam logic [5:0] OFS_OUTPUT_CTRL   = 6'h08;
	localparam logic [5:0] OFS_CAPTURE_EDGE  = 6'h0c;
	localparam logic [5:0] OFS_EVENT_EDGE    = 6'h10;
	localparam logic [5:0] OFS_OPTION        = 6'h14;
	localparam logic [5:0] OFS_CAPCMP_0      = 6'h18;
	localparam logic [5:0] OFS_CAPCMP_1      = 6'h1c;
	localparam logic [5:0] OFS_READ_BUFFER   = 6'h20;
	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int BIT_CHANNEL_ENABLE   = 7;
	localparam int BIT_EVENT_ENABLE     = 5;
	localparam int BIT_SW_TRIGGER       = 6;
	localparam int BIT_OE0              = 0;
	localparam int BIT_OL0              = 1;
	localparam int BIT_OE1              = 2;
	localparam int BIT_OL1              = 3;
	localparam int POS_CAP_EDGE0        = 0;
	localparam int POS_CAP_EDGE1        = 2;
	localparam int POS_TRIG_EDGE        = 0;
	localparam int POS_EVENT_EDGE       = 2;
	localparam int BIT_CCS0             = 4;
	localparam int BIT_CCS1             = 5;
	localparam int BIT_OVERFLOW         = 0;
	// ---------------------------------------------------------------
	// reset values
	// ---------------------------------------------------------------
	localparam logic [7:0]  RST_REG8    = 8'h00;
	localparam logic [15:0] RST_CAPCMP  = 16'h0000;
	localparam logic [15:0] CNT_IDLE    = 16'hffff;
	localparam logic [15:0] CNT_ZERO    = 16'h0000;
	// ---------------------------------------------------------------
	// prescaler
	// ---------------------------------------------------------------
	localparam int          PRESC_W     = 9;
	localparam logic [3:0]  ODD_SHIFT6  = 4'h8;
	localparam logic [3:0]  ODD_SHIFT7  = 4'h9;
	// ---------------------------------------------------------------
	// types
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		MODE_INTERVAL  = 3'b000,
		MODE_FREE_RUN  = 3'b101
	} mode_t;
	typedef enum logic {
		BUS_IDLE = 1'b0,
		BUS_DONE = 1'b1
	} bus_state_t;
endpackage : timer_channel_pkg

// [logic/timer_channel.sv]
`timescale 1ns/1ns
module timer_channel #(
	parameter bit         ODD_CHANNEL   = 1'b0,
	parameter logic [7:0] MASK_CONTROL1 = 8'h67,
	parameter logic [7:0] MASK_OUTPUT   = 8'h0f,
	parameter logic [7:0] MASK_CAPEDGE  = 8'h0f,
	parameter logic [7:0] MASK_EVEDGE   = 8'h0f,
	parameter logic [7:0] MASK_OPTION   = 8'h31
) (
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst_b,
	input  wire logic        ce,
	// avalon-mm slave
	input  wire logic [5:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	output logic [31:0]      readdata,
	output logic             waitrequest,
	// timer pins
	input  wire logic        timer_input_0,
	input  wire logic        timer_input_1,
	output logic             timer_output_0,
	output logic             timer_output_1,
	// interrupt requests
	output logic             match_irq_0,
	output logic             match_irq_1,
	output logic             overflow_irq
);
	import timer_channel_pkg::*;

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic valid_edge(input logic [1:0] sel, input logic cur,
		input logic prev);
		valid_edge = (sel[0] & cur & ~prev) | (sel[1] & ~cur & prev);
	endfunction : valid_edge

	bus_state_t  bus_r;
	logic [7:0]  control0_r, control1_r, out_ctl_r, cap_edge_r, ev_edge_r, option_r;
	logic [15:0] capcmp0_r, capcmp1_r, cmpbuf0_r, cmpbuf1_r, cnt_r;
	logic [PRESC_W-1:0] presc_r;
	logic        running_r, toggle0_r, toggle1_r;
	logic [1:0]  in0_sync_r, in1_sync_r;
	logic        in0_prev_r, in1_prev_r;
	logic        enabled, ext_count, presc_tick, tick, ev_edge, cap0_ev, cap1_ev;
	logic        match0, match1, ovf_ev, wr_acc, wr_cap0, wr_cap1;
	logic [3:0]  div_shift;
	logic [PRESC_W-1:0] div_mask;
	logic [7:0]  wr8;
	logic [31:0] rd_nxt;

	assign enabled   = control0_r[BIT_CHANNEL_ENABLE];
	assign ext_count = control1_r[BIT_EVENT_ENABLE];
	assign wr_acc    = write && bus_r == BUS_DONE;
	assign wr8       = writedata[7:0];
	assign wr_cap0   = wr_acc && address == OFS_CAPCMP_0;
	assign wr_cap1   = wr_acc && address == OFS_CAPCMP_1;

	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	// second stage only feeds the edge detectors; first stage stays private
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			in0_sync_r <= 2'b00;
			in1_sync_r <= 2'b00;
			in0_prev_r <= 1'b0;
			in1_prev_r <= 1'b0;
		end else if (ce) begin
			in0_sync_r <= {in0_sync_r[0], timer_input_0};
			in1_sync_r <= {in1_sync_r[0], timer_input_1};
			in0_prev_r <= in0_sync_r[1];
			in1_prev_r <= in1_sync_r[1];
		end
	end

	// input 0 doubles as event source and capture 0 trigger
	assign ev_edge = valid_edge(ev_edge_r[POS_EVENT_EDGE+:2], in0_sync_r[1], in0_prev_r);
	assign cap0_ev = enabled && option_r[BIT_CCS0] &&
		valid_edge(cap_edge_r[POS_CAP_EDGE0+:2], in0_sync_r[1], in0_prev_r);
	assign cap1_ev = enabled && option_r[BIT_CCS1] &&
		valid_edge(cap_edge_r[POS_CAP_EDGE1+:2], in1_sync_r[1], in1_prev_r);

	// ---------------------------------------------------------------
	// count clock selector
	// ---------------------------------------------------------------
	always_comb begin
		div_shift = {1'b0, control0_r[2:0]};
		if (ODD_CHANNEL && control0_r[2:1] == 2'b11)
			div_shift = control0_r[0] ? ODD_SHIFT7 : ODD_SHIFT6;
		div_mask = PRESC_W'((1 << div_shift) - 1);
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b)
			presc_r <= '0;
		else if (ce) begin
			if (!enabled)
				presc_r <= '0;
			else
				presc_r <= presc_r + 1'b1;
		end
	end

	assign presc_tick = (presc_r & div_mask) == div_mask;
	assign tick = enabled && (ext_count ? ev_edge : presc_tick);

	// ---------------------------------------------------------------
	// counter, compare and overflow
	// ---------------------------------------------------------------
	// compare is on the tick that leaves the matching value
	assign match0 = tick && running_r && !option_r[BIT_CCS0] && cnt_r == cmpbuf0_r;
	assign match1 = tick && running_r && !option_r[BIT_CCS1] && cnt_r == cmpbuf1_r;
	assign ovf_ev = tick && running_r && cnt_r == CNT_IDLE &&
		!(control1_r[2:0] == MODE_INTERVAL && match0);

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			cnt_r     <= CNT_IDLE;
			running_r <= 1'b0;
		end else if (ce) begin
			if (!enabled) begin
				cnt_r     <= CNT_IDLE;
				running_r <= 1'b0;
			end else if (tick) begin
				running_r <= 1'b1;
				if (!running_r)
					cnt_r <= CNT_ZERO;
				else if (control1_r[2:0] == MODE_INTERVAL && match0)
					cnt_r <= CNT_ZERO;
				else
					cnt_r <= cnt_r + 1'b1;
			end
		end
	end

	// hidden compare buffers, loaded on compare-mode writes only
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			cmpbuf0_r <= RST_CAPCMP;
			cmpbuf1_r <= RST_CAPCMP;
		end else if (ce) begin
			if (wr_cap0 && !option_r[BIT_CCS0])
				cmpbuf0_r <= writedata[15:0];
			if (wr_cap1 && !option_r[BIT_CCS1])
				cmpbuf1_r <= writedata[15:0];
		end
	end

	// capture wins over a software write in the same cycle
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			capcmp0_r <= RST_CAPCMP;
			capcmp1_r <= RST_CAPCMP;
		end else if (ce) begin
			if (cap0_ev)
				capcmp0_r <= cnt_r;
			else if (wr_cap0)
				capcmp0_r <= writedata[15:0];
			if (cap1_ev)
				capcmp1_r <= cnt_r;
			else if (wr_cap1)
				capcmp1_r <= writedata[15:0];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			match_irq_0  <= 1'b0;
			match_irq_1  <= 1'b0;
			overflow_irq <= 1'b0;
		end else if (ce) begin
			match_irq_0  <= match0 || cap0_ev;
			match_irq_1  <= match1 || cap1_ev;
			overflow_irq <= ovf_ev;
		end
	end

	// ---------------------------------------------------------------
	// output controller
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			toggle0_r      <= 1'b0;
			toggle1_r      <= 1'b0;
			timer_output_0 <= 1'b0;
			timer_output_1 <= 1'b0;
		end else if (ce) begin
			if (!enabled) begin
				toggle0_r <= 1'b0;
				toggle1_r <= 1'b0;
			end else begin
				toggle0_r <= toggle0_r ^ match0;
				toggle1_r <= toggle1_r ^ match1;
			end
			// level bit inverts the active sense; disabled pin rests at zero
			timer_output_0 <= out_ctl_r[BIT_OE0] & (toggle0_r ^ out_ctl_r[BIT_OL0]);
			timer_output_1 <= out_ctl_r[BIT_OE1] & (toggle1_r ^ out_ctl_r[BIT_OL1]);
		end
	end

	// ---------------------------------------------------------------
	// control registers
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			control0_r <= RST_REG8;
			control1_r <= RST_REG8;
			out_ctl_r  <= RST_REG8;
			cap_edge_r <= RST_REG8;
			ev_edge_r  <= RST_REG8;
		end else if (ce && wr_acc) begin
			case (address)
				OFS_CONTROL_0:    control0_r <= wr8 & 8'h87;
				OFS_CONTROL_1:    control1_r <= wr8 & MASK_CONTROL1 & ~8'h40;
				OFS_OUTPUT_CTRL:  out_ctl_r  <= wr8 & MASK_OUTPUT;
				OFS_CAPTURE_EDGE: cap_edge_r <= wr8 & MASK_CAPEDGE;
				OFS_EVENT_EDGE:   ev_edge_r  <= wr8 & MASK_EVEDGE;
				default: ;
			endcase
		end
	end

	// overflow flag: hardware set beats a software clear
	always_ff @(posedge sys_clk) begin
		if (!rst_b)
			option_r <= RST_REG8;
		else if (ce) begin
			if (wr_acc && address == OFS_OPTION)
				option_r <= (wr8 & MASK_OPTION & 8'hfe) |
					{7'h00, option_r[BIT_OVERFLOW] & wr8[BIT_OVERFLOW]};
			if (!enabled)
				option_r[BIT_OVERFLOW] <= 1'b0;
			else if (ovf_ev && MASK_OPTION[BIT_OVERFLOW])
				option_r[BIT_OVERFLOW] <= 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// bus slave
	// ---------------------------------------------------------------
	always_comb begin
		rd_nxt = 32'h0000_0000;
		case (address)
			OFS_CONTROL_0:    rd_nxt[7:0]  = control0_r;
			OFS_CONTROL_1:    rd_nxt[7:0]  = control1_r;
			OFS_OUTPUT_CTRL:  rd_nxt[7:0]  = out_ctl_r;
			OFS_CAPTURE_EDGE: rd_nxt[7:0]  = cap_edge_r;
			OFS_EVENT_EDGE:   rd_nxt[7:0]  = ev_edge_r;
			OFS_OPTION:       rd_nxt[7:0]  = option_r;
			OFS_CAPCMP_0:     rd_nxt[15:0] = capcmp0_r;
			OFS_CAPCMP_1:     rd_nxt[15:0] = capcmp1_r;
			OFS_READ_BUFFER:  rd_nxt[15:0] = enabled ? cnt_r : CNT_ZERO;
			default:          rd_nxt       = 32'h0000_0000;
		endcase
	end

	// one wait cycle per access; write lands on the edge waitrequest is low
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			bus_r       <= BUS_IDLE;
			waitrequest <= 1'b1;
			readdata    <= 32'h0000_0000;
		end else if (ce) begin
			case (bus_r)
				BUS_IDLE: begin
					if (read || write) begin
						bus_r       <= BUS_DONE;
						waitrequest <= 1'b0;
						readdata    <= rd_nxt;
					end
				end
				BUS_DONE: begin
					bus_r       <= BUS_IDLE;
					waitrequest <= 1'b1;
				end
				default: begin
					bus_r       <= BUS_IDLE;
					waitrequest <= 1'b1;
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	a_idle_count: assert property (@(posedge sys_clk) disable iff (!rst_b)
		ce && !enabled |=> cnt_r == CNT_IDLE)
		else $error("counter not parked while disabled");
	a_buffer_reads_zero: assert property (@(posedge sys_clk) disable iff (!rst_b)
		ce && bus_r == BUS_IDLE && read && address == OFS_READ_BUFFER && !enabled
		|=> readdata == 32'h0 && !waitrequest)
		else $error("read buffer not zero while disabled");
	a_match0_pulse: assert property (@(posedge sys_clk) disable iff (!rst_b)
		ce && tick && running_r && !option_r[BIT_CCS0] && cnt_r == cmpbuf0_r
		|=> match_irq_0)
		else $error("match 0 missed");
	a_match1_pulse: assert property (@(posedge sys_clk) disable iff (!rst_b)
		ce && tick && running_r && !option_r[BIT_CCS1] && cnt_r == cmpbuf1_r
		|=> match_irq_1)
		else $error("match 1 missed");
	a_buffer0_load: assert property (@(posedge sys_clk) disable iff (!rst_b)
		ce && wr_cap0 && !option_r[BIT_CCS0] |=> cmpbuf0_r == $past(writedata[15:0]))
		else $error("compare buffer 0 not loaded");
	a_capture1_value: assert property (@(posedge sys_clk) disable iff (!rst_b)
		ce && cap1_ev |=> capcmp1_r == $past(cnt_r) && match_irq_1)
		else $error("capture 1 wrong");
	a_overflow_flag: assert property (@(posedge sys_clk) disable iff (!rst_b)
		overflow_irq |-> option_r[BIT_OVERFLOW] == MASK_OPTION[BIT_OVERFLOW]
		&& cnt_r == CNT_ZERO)
		else $error("overflow pulse without flag");
	a_count_step: assert property (@(posedge sys_clk) disable iff (!rst_b)
		ce && enabled && running_r && !tick |=> cnt_r == $past(cnt_r))
		else $error("counter moved without tick");
	a_output_off: assert property (@(posedge sys_clk) disable iff (!rst_b)
		ce && !out_ctl_r[BIT_OE0] |=> !timer_output_0)
		else $error("output 0 driven while disabled");
	a_wait_one: assert property (@(posedge sys_clk) disable iff (!rst_b)
		ce && bus_r == BUS_IDLE && (read || write) |=> !waitrequest ##1 waitrequest)
		else $error("bus answer timing wrong");
	a_wait_idle: assert property (@(posedge sys_clk) disable iff (!rst_b)
		ce && bus_r == BUS_DONE |=> waitrequest)
		else $error("waitrequest not restored after answer");
	a_overflow_clear: assert property (@(posedge sys_clk) disable iff (!rst_b)
		ce && !enabled |=> !option_r[BIT_OVERFLOW])
		else $error("overflow flag kept while disabled");
	a_irq_quiet: assert property (@(posedge sys_clk) disable iff (!rst_b)
		ce && !enabled |=> !match_irq_0 && !match_irq_1 && !overflow_irq)
		else $error("interrupt pulse while disabled");
	a_buffer1_load: assert property (@(posedge sys_clk) disable iff (!rst_b)
		ce && wr_cap1 && !option_r[BIT_CCS1] |=> cmpbuf1_r == $past(writedata[15:0]))
		else $error("compare buffer 1 not loaded");
	a_event_step: assert property (@(posedge sys_clk) disable iff (!rst_b)
		ce && enabled && running_r && ext_count && ev_edge && control1_r[2:0] != MODE_INTERVAL
		|=> cnt_r == $past(cnt_r) + 16'h0001)
		else $error("event edge did not advance counter");
	a_prescaler_rest: assert property (@(posedge sys_clk) disable iff (!rst_b)
		ce && !enabled |=> presc_r == '0)
		else $error("prescaler running while disabled");
	a_capture0_value: assert property (@(posedge sys_clk) disable iff (!rst_b)
		ce && cap0_ev |=> capcmp0_r == $past(cnt_r) && match_irq_0)
		else $error("capture 0 wrong");
	a_freeze_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
		!ce |=> cnt_r == $past(cnt_r) && waitrequest == $past(waitrequest))
		else $error("state moved while clock enable low");
endmodule : timer_channel

// [verification/pin_partner.sv]
`timescale 1ns/1ns
module pin_partner (
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst_b,
	// bench request, one bit per pin
	input  wire logic [1:0] pulse_req,
	// pins toward the channel
	output logic            timer_input_0,
	output logic            timer_input_1
);
	logic [2:0] hold0_r;
	logic [2:0] hold1_r;

	// ---------------------------------------------------------------
	// pulse shaping
	// ---------------------------------------------------------------
	// four cycles high keeps each level well past the two-flop sync
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			hold0_r <= 3'h0;
			hold1_r <= 3'h0;
		end else begin
			hold0_r <= pulse_req[0] ? 3'h4 : hold0_r - {2'h0, hold0_r != 3'h0};
			hold1_r <= pulse_req[1] ? 3'h4 : hold1_r - {2'h0, hold1_r != 3'h0};
		end
	end

	// pins rest low until the bench has set the channel up
	assign timer_input_0 = (hold0_r != 3'h0);
	assign timer_input_1 = (hold1_r != 3'h0);
endmodule : pin_partner

// [verification/timer_event_counter_core_tb.sv]
`timescale 1ns/1ns
module timer_event_counter_core_tb;
	import timer_channel_pkg::*;
	// ---------------------------------------------------------------
	// signals
	// ---------------------------------------------------------------
	logic        sys_clk, rst_b, ce, read, write, waitrequest;
	logic [5:0]  address;
	logic [31:0] writedata, readdata, d;
	logic        timer_input_0, timer_input_1, timer_output_0, timer_output_1;
	logic        match_irq_0, match_irq_1, overflow_irq;
	logic [1:0]  pulse_req;
	logic [31:0] exp_q[$];
	int          n_fail, samples_checked, cyc, base;
	int          n_irq0, n_irq1, n_ovf, t0, t0_prev, t1, tov;
	logic [5:0]  ofs[8] = '{OFS_CONTROL_0, OFS_CONTROL_1, OFS_OUTPUT_CTRL, OFS_CAPTURE_EDGE,
		OFS_EVENT_EDGE, OFS_OPTION, OFS_CAPCMP_0, OFS_CAPCMP_1};
	// trigger bit never stores, overflow flag is not settable by software
	logic [31:0] msk[8] = '{32'h07, 32'h27, 32'h0f, 32'h0f, 32'h0f, 32'h30, 32'hffff, 32'hffff};
	logic [7:0]  oc[5] = '{8'h0f, 8'h05, 8'h0a, 8'h03, 8'h0c};
	int          ecnt[4] = '{0, 1, 1, 2};

	timer_channel uut (.sys_clk(sys_clk), .rst_b(rst_b), .ce(ce), .address(address),
		.read(read), .write(write), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .timer_input_0(timer_input_0),
		.timer_input_1(timer_input_1), .timer_output_0(timer_output_0),
		.timer_output_1(timer_output_1), .match_irq_0(match_irq_0),
		.match_irq_1(match_irq_1), .overflow_irq(overflow_irq));

	pin_partner far_pins (.sys_clk(sys_clk), .rst_b(rst_b), .pulse_req(pulse_req),
		.timer_input_0(timer_input_0), .timer_input_1(timer_input_1));

	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	// ---------------------------------------------------------------
	// checking and bus tasks
	// ---------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] expv);
		samples_checked++;
		if (seen !== expv) begin
			n_fail++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, expv);
		end
	endtask : check

	task final_report;
		$display("comparisons %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : final_report

	// request held until waitrequest is sampled low, released at that edge
	task automatic bus_xfer(input logic wr, input logic [5:0] a, input logic [31:0] wd);
		int k;
		k = 0;
		@(posedge sys_clk);
		address   <= a;
		writedata <= wd;
		write     <= wr;
		read      <= ~wr;
		do begin
			@(posedge sys_clk);
			k++;
		end while (waitrequest !== 1'b0 && k < 50);
		if (k >= 50) begin
			n_fail++;
			final_report();
		end
		read  <= 1'b0;
		write <= 1'b0;
	endtask : bus_xfer

	task automatic rd(input logic [5:0] a, input logic [31:0] expv);
		exp_q.push_back(expv);
		bus_xfer(1'b0, a, 32'h0);
	endtask : rd

	task automatic wr(input logic [5:0] a, input logic [31:0] wd);
		bus_xfer(1'b1, a, wd);
	endtask : wr

	task automatic wait_for(ref int n, input int target);
		for (int i = 0; i < 70000 && n < target; i++) @(posedge sys_clk);
		if (n < target) begin
			n_fail++;
			final_report();
		end
	endtask : wait_for

	// ---------------------------------------------------------------
	// observers
	// ---------------------------------------------------------------
	always @(posedge sys_clk) begin
		if (read === 1'b1 && waitrequest === 1'b0 && exp_q.size() > 0)
			check(readdata, exp_q.pop_front());
	end

	// irq pulses stamped with the cycle they were seen in
	always @(posedge sys_clk) begin
		cyc++;
		if (match_irq_0 === 1'b1) begin
			n_irq0++;
			t0_prev = t0;
			t0 = cyc;
		end
		if (match_irq_1 === 1'b1) begin
			n_irq1++;
			t1 = cyc;
		end
		if (overflow_irq === 1'b1) begin
			n_ovf++;
			tov = cyc;
		end
		if (cyc == 80000) begin
			n_fail++;
			final_report();
		end
	end

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		rst_b = 1'b0;
		ce = 1'b1;
		address = 6'h00;
		read = 1'b0;
		write = 1'b0;
		writedata = 32'h0;
		pulse_req = 2'h0;
		void'($urandom(69279));
		repeat (12) @(posedge sys_clk);
		rst_b <= 1'b1;
		foreach (ofs[i]) rd(ofs[i], 32'h0);
		rd(OFS_READ_BUFFER, 32'h0);
		foreach (ofs[i]) begin
			d = $urandom() & ((i == 0) ? 32'h7f : 32'hffffffff);
			wr(ofs[i], d);
			rd(ofs[i], d & msk[i]);
		end
		wr(6'h24, $urandom());
		rd(6'h24, 32'h0);
		foreach (ofs[i]) wr(ofs[i], 32'h0);
		$display("registers done");
		foreach (oc[i]) begin
			wr(OFS_OUTPUT_CTRL, {24'h0, oc[i]});
			repeat (3) @(posedge sys_clk);
			check({timer_output_1, timer_output_0}, {oc[i][2] & oc[i][3], oc[i][0] & oc[i][1]});
		end
		$display("outputs done");
		wr(OFS_OUTPUT_CTRL, 32'h05);
		wr(OFS_CAPCMP_0, 32'h2);
		for (int code = 0; code < 8; code++) begin
			wr(OFS_CONTROL_0, 32'h80 | code);
			wait_for(n_irq0, n_irq0 + 3);
			check(t0 - t0_prev, 32'h3 << code);
			wr(OFS_CONTROL_0, 32'h0);
			repeat (3) @(posedge sys_clk);
			check({31'h0, timer_output_0}, 32'h0);
			rd(OFS_READ_BUFFER, 32'h0);
		end
		// ten frozen edges stretch one period of three ticks to thirteen
		wr(OFS_CONTROL_0, 32'h80);
		wait_for(n_irq0, n_irq0 + 2);
		ce <= 1'b0;
		repeat (10) @(posedge sys_clk);
		ce <= 1'b1;
		wait_for(n_irq0, n_irq0 + 1);
		check(t0 - t0_prev, 32'd13);
		wr(OFS_CONTROL_0, 32'h0);
		$display("interval done");
		wr(OFS_CONTROL_1, 32'h05);
		wr(OFS_OPTION, 32'h30);
		wr(OFS_CONTROL_0, 32'h80);
		for (int pin = 0; pin < 2; pin++) begin
			for (int code = 0; code < 4; code++) begin
				wr(OFS_CAPTURE_EDGE, code << (2 * pin));
				base = pin ? n_irq1 : n_irq0;
				@(posedge sys_clk);
				pulse_req <= 2'h1 << pin;
				@(posedge sys_clk);
				pulse_req <= 2'h0;
				repeat (14) @(posedge sys_clk);
				check((pin ? n_irq1 : n_irq0) - base, ecnt[code]);
			end
		end
		wr(OFS_CONTROL_0, 32'h0);
		wr(OFS_OPTION, 32'h0);
		$display("capture done");
		wr(OFS_CAPCMP_0, 32'h0010);
		wr(OFS_CAPCMP_1, 32'hfff0);
		wr(OFS_CONTROL_0, 32'h80);
		wait_for(n_ovf, n_ovf + 1);
		check(t1 - t0, 32'hffe0);
		check(tov - t1, 32'hf);
		rd(OFS_OPTION, 32'h01);
		wr(OFS_CONTROL_0, 32'h0);
		rd(OFS_OPTION, 32'h0);
		rd(OFS_READ_BUFFER, 32'h0);
		repeat (3) @(posedge sys_clk);
		$display("free run done");
		// rising event edges on input 0; first edge only loads zero
		wr(OFS_CONTROL_1, 32'h25);
		wr(OFS_EVENT_EDGE, 32'h04);
		wr(OFS_CONTROL_0, 32'h80);
		repeat (4) begin
			@(posedge sys_clk);
			pulse_req <= 2'h1;
			@(posedge sys_clk);
			pulse_req <= 2'h0;
			repeat (10) @(posedge sys_clk);
		end
		rd(OFS_READ_BUFFER, 32'h3);
		wr(OFS_CONTROL_0, 32'h0);
		$display("event count done");
		final_report();
	end
endmodule : timer_event_counter_core_tb
